//--- logic/fbx_cond.sv
// branch condition decode
`timescale 1ns/1ps
module fbx_cond
   import fbx_pkg::*;
(
   input wire fbx_op_t op,
   input wire fbx_flags_t flags,
   output logic is_branch,
   output logic taken
);
   always_comb
   begin
      is_branch = 1'b1;
      taken = 1'b0;
      case (op)
         FBX_OP_BR_TSET: taken = flags.t_bit;
         FBX_OP_BR_TCLR: taken = ~flags.t_bit;
         FBX_OP_BR_VSET: taken = flags.v_flag;
         FBX_OP_BR_VCLR: taken = ~flags.v_flag;
         FBX_OP_BR_IEN: taken = flags.i_flag;
         FBX_OP_BR_IDIS: taken = ~flags.i_flag;
         default: is_branch = 1'b0;
      endcase
   end
endmodule : fbx_cond

//--- logic/fbx_exec.sv
// execution of flag branches and the io bit set operation
`timescale 1ns/1ps
`include "fbx_regs.svh"
module fbx_exec
   import fbx_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic INSTR_VALID,
   input wire fbx_instr_t INSTR,
   input wire fbx_flags_t FLAGS,
   input wire logic [`FBX_PC_W-1:0] PC,
   input wire logic [7:0] IO_RDATA,
   output logic BUSY,
   output logic DONE,
   output logic PC_LOAD,
   output logic [`FBX_PC_W-1:0] PC_NEXT,
   output logic IO_RD,
   output logic IO_WE,
   output logic [`FBX_IO_AW-1:0] IO_ADDR,
   output logic [7:0] IO_WDATA
);
   // ****************************************
   // state
   // ****************************************
   typedef enum logic [1:0] {S_IDLE, S_BR2, S_IO_WR} fbx_state_t;
   fbx_state_t state, next_state;
   logic busy, next_busy;
   logic done, next_done;
   logic pc_load, next_pc_load;
   logic [`FBX_PC_W-1:0] pc_next, next_pc_next;
   logic io_rd, next_io_rd;
   logic io_we, next_io_we;
   logic [`FBX_IO_AW-1:0] io_addr, next_io_addr;
   logic [7:0] io_wdata, next_io_wdata;
   logic [2:0] bit_sel, next_bit_sel;
   logic is_branch;
   logic taken;
   logic [`FBX_PC_W-1:0] target;

   fbx_cond u_cond
   (
      .op(INSTR.op),
      .flags(FLAGS),
      .is_branch(is_branch),
      .taken(taken)
   );

   // offset is signed; sign extended before the add
   assign target = PC + {{(`FBX_PC_W-`FBX_OFS_W){INSTR.offset[`FBX_OFS_W-1]}}, INSTR.offset}
      + `FBX_PC_STEP;

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      next_state = state;
      next_busy = 1'b0;
      next_done = 1'b0;
      next_pc_load = 1'b0;
      next_pc_next = pc_next;
      next_io_rd = 1'b0;
      next_io_we = 1'b0;
      next_io_addr = io_addr;
      next_io_wdata = io_wdata;
      next_bit_sel = bit_sel;
      case (state)
         S_IDLE:
         begin
            if (INSTR_VALID && is_branch)
            begin
               if (taken)
               begin
                  next_state = S_BR2;
                  next_busy = 1'b1;
                  next_pc_next = target;
               end
               else
               begin
                  next_done = 1'b1;
               end
            end
            else if (INSTR_VALID && INSTR.op == FBX_OP_IO_BIT_SET)
            begin
               // read first so unselected bits survive
               next_state = S_IO_WR;
               next_busy = 1'b1;
               next_io_rd = 1'b1;
               next_io_addr = INSTR.io_addr;
               next_bit_sel = INSTR.bit_sel;
            end
         end
         S_BR2:
         begin
            next_state = S_IDLE;
            next_pc_load = 1'b1;
            next_done = 1'b1;
         end
         S_IO_WR:
         begin
            next_state = S_IDLE;
            next_io_we = 1'b1;
            next_io_wdata = IO_RDATA | (8'h01 << bit_sel);
            next_done = 1'b1;
         end
         default: next_state = S_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
      begin
         state <= S_IDLE;
         busy <= 1'b0;
         done <= 1'b0;
         pc_load <= 1'b0;
         pc_next <= '0;
         io_rd <= 1'b0;
         io_we <= 1'b0;
         io_addr <= '0;
         io_wdata <= 8'h00;
         bit_sel <= 3'h0;
      end
      else
      begin
         state <= next_state;
         busy <= next_busy;
         done <= next_done;
         pc_load <= next_pc_load;
         pc_next <= next_pc_next;
         io_rd <= next_io_rd;
         io_we <= next_io_we;
         io_addr <= next_io_addr;
         io_wdata <= next_io_wdata;
         bit_sel <= next_bit_sel;
      end
   end

   assign BUSY = busy;
   assign DONE = done;
   assign PC_LOAD = pc_load;
   assign PC_NEXT = pc_next;
   assign IO_RD = io_rd;
   assign IO_WE = io_we;
   assign IO_ADDR = io_addr;
   assign IO_WDATA = io_wdata;

   // ****************************************
   // checks
   // ****************************************
   property p_taken_two;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (INSTR_VALID && !BUSY && is_branch && taken) |-> ##1 !DONE ##1 (DONE && PC_LOAD);
   endproperty
   a_taken_two: assert property (p_taken_two) else $error("taken branch not two cycles");

   property p_not_taken_one;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (INSTR_VALID && !BUSY && is_branch && !taken) |=> (DONE && !PC_LOAD);
   endproperty
   a_not_taken_one: assert property (p_not_taken_one) else $error("fall through wrong");

   property p_target;
      @(posedge CLK_SYS) disable iff (!RSTN)
      // expected target built from the sampled pc and offset, not from the adder under test
      (INSTR_VALID && !BUSY && is_branch && taken) |-> ##2
         (PC_NEXT == 16'($signed($past(INSTR.offset, 2))) + $past(PC, 2) + `FBX_PC_STEP);
   endproperty
   a_target: assert property (p_target) else $error("branch target wrong");

   property p_tclr;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (INSTR_VALID && !BUSY && INSTR.op == FBX_OP_BR_TCLR && !FLAGS.t_bit) |=> BUSY;
   endproperty
   a_tclr: assert property (p_tclr) else $error("transfer clear not taken");

   property p_tset;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (INSTR_VALID && !BUSY && INSTR.op == FBX_OP_BR_TSET && !FLAGS.t_bit) |=> !BUSY;
   endproperty
   a_tset: assert property (p_tset) else $error("transfer set taken wrongly");

   property p_vset;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (INSTR_VALID && !BUSY && INSTR.op == FBX_OP_BR_VSET && FLAGS.v_flag) |=> ##1 PC_LOAD;
   endproperty
   a_vset: assert property (p_vset) else $error("overflow set not taken");

   property p_vclr;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (INSTR_VALID && !BUSY && INSTR.op == FBX_OP_BR_VCLR && FLAGS.v_flag) |=> !BUSY;
   endproperty
   a_vclr: assert property (p_vclr) else $error("overflow clear wrong");

   property p_ien;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (INSTR_VALID && !BUSY && INSTR.op == FBX_OP_BR_IEN && FLAGS.i_flag) |=> BUSY;
   endproperty
   a_ien: assert property (p_ien) else $error("interrupt enabled branch wrong");

   property p_idis;
      @(posedge CLK_SYS) disable iff (!RSTN)
      (INSTR_VALID && !BUSY && INSTR.op == FBX_OP_BR_IDIS && FLAGS.i_flag) |=> !BUSY;
   endproperty
   a_idis: assert property (p_idis) else $error("interrupt disabled branch wrong");

   property p_bit_set;
      @(posedge CLK_SYS) disable iff (!RSTN)
      IO_WE |-> (IO_WDATA == ($past(IO_RDATA) | (8'h01 << $past(bit_sel))));
   endproperty
   a_bit_set: assert property (p_bit_set) else $error("io bit set wrong");

   c_taken: cover property (@(posedge CLK_SYS) disable iff (!RSTN) PC_LOAD);
   c_fall: cover property (@(posedge CLK_SYS) disable iff (!RSTN) DONE && !PC_LOAD && !IO_WE);
   c_io: cover property (@(posedge CLK_SYS) disable iff (!RSTN) IO_WE);
endmodule : fbx_exec

//--- logic/fbx_pkg.sv
// types for the flag branch and io bit set execution block
`include "fbx_regs.svh"
package fbx_pkg;
   typedef enum logic [2:0] {
      FBX_OP_NONE,
      FBX_OP_BR_TSET,
      FBX_OP_BR_TCLR,
      FBX_OP_BR_VSET,
      FBX_OP_BR_VCLR,
      FBX_OP_BR_IEN,
      FBX_OP_BR_IDIS,
      FBX_OP_IO_BIT_SET
   } fbx_op_t;
   typedef struct packed {
      fbx_op_t op;
      logic [`FBX_OFS_W-1:0] offset;
      logic [`FBX_IO_AW-1:0] io_addr;
      logic [2:0] bit_sel;
   } fbx_instr_t;
   typedef struct packed {
      logic t_bit;
      logic v_flag;
      logic i_flag;
   } fbx_flags_t;
endpackage : fbx_pkg

//--- logic/fbx_regs.svh
// constants for the flag branch and io bit set execution block
//
// Contract
// - transfer bit clear: pc gets pc plus offset plus one
// - transfer bit set: pc gets pc plus offset plus one
// - overflow set: pc gets pc plus offset plus one
// - overflow clear: pc gets pc plus offset plus one
// - interrupts enabled: jump pc plus offset plus one
// - interrupts disabled: jump pc plus offset plus one
// - io bit set, other bits unchanged
// - branches change no flag, take 1 or 2 cycles
`ifndef FBX_REGS_SVH
`define FBX_REGS_SVH
`define FBX_PC_W 16
`define FBX_OFS_W 7
`define FBX_IO_AW 6
`define FBX_PC_STEP 16'h0001
`define FBX_SBI_CYCLES 2'h2
`endif

//--- verification/flag_branch_and_bit_set_exec_test.sv
// self-checking bench for the flag branch and io bit set block
`timescale 1ns/1ps
`include "fbx_regs.svh"
module flag_branch_and_bit_set_exec_test
   import fbx_pkg::*;
();
   // ********************************
   // signals and design instance
   // ********************************
   logic CLK_SYS;
   logic RSTN;
   logic INSTR_VALID;
   fbx_instr_t INSTR;
   fbx_flags_t FLAGS;
   logic [`FBX_PC_W-1:0] PC;
   logic [7:0] IO_RDATA;
   logic BUSY, DONE, PC_LOAD, IO_RD, IO_WE;
   logic [`FBX_PC_W-1:0] PC_NEXT;
   logic [`FBX_IO_AW-1:0] IO_ADDR;
   logic [7:0] IO_WDATA;
   int errors = 0;
   int checks_done = 0;
   int cycles = 0;
   int seed = 4;
   logic [31:0] r;
   logic [31:0] r2;

   fbx_exec dut_u (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
      .FLAGS(FLAGS), .PC(PC), .IO_RDATA(IO_RDATA), .BUSY(BUSY), .DONE(DONE),
      .PC_LOAD(PC_LOAD), .PC_NEXT(PC_NEXT), .IO_RD(IO_RD), .IO_WE(IO_WE),
      .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA));

   always #12.5 CLK_SYS = ~CLK_SYS;

   // ********************************
   // helpers
   // ********************************
   function automatic logic exp_taken(input fbx_op_t op, input fbx_flags_t f);
      case (op)
         FBX_OP_BR_TSET: exp_taken = f.t_bit;
         FBX_OP_BR_TCLR: exp_taken = !f.t_bit;
         FBX_OP_BR_VSET: exp_taken = f.v_flag;
         FBX_OP_BR_VCLR: exp_taken = !f.v_flag;
         FBX_OP_BR_IEN: exp_taken = f.i_flag;
         FBX_OP_BR_IDIS: exp_taken = !f.i_flag;
         default: exp_taken = 1'b0;
      endcase
   endfunction : exp_taken

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   // valid stays high while busy, so the held request doubles as a refused one
   task automatic issue(input fbx_op_t op, input logic [6:0] ofs, input fbx_flags_t fl,
      input logic [15:0] pc, input logic [2:0] bsel, input logic [7:0] rd);
      logic tk;
      logic io;
      logic nn;
      tk = exp_taken(op, fl);
      io = (op == FBX_OP_IO_BIT_SET);
      nn = (op == FBX_OP_NONE);
      INSTR = '{op, ofs, pc[5:0], bsel};
      FLAGS = fl;
      PC = pc;
      INSTR_VALID = 1'b1;
      @(posedge CLK_SYS);
      @(negedge CLK_SYS);
      chk(DONE, !(tk || io || nn));
      chk(BUSY, tk || io);
      chk(PC_LOAD, 1'b0);
      chk(IO_RD, io);
      if (io)
         chk(IO_ADDR, pc[5:0]);
      if (tk || io)
      begin
         IO_RDATA = rd;
         @(posedge CLK_SYS);
         @(negedge CLK_SYS);
         chk(DONE, 1'b1);
         chk({BUSY, IO_RD}, 2'h0);
         chk(PC_LOAD, tk);
         chk(IO_WE, io);
         if (tk)
            chk(PC_NEXT, pc + {{9{ofs[6]}}, ofs} + 16'h0001);
         if (io)
            chk(IO_WDATA, rd | (8'h01 << bsel));
      end
   endtask : issue

   // ********************************
   // sequence and timeout
   // ********************************
   always @(posedge CLK_SYS)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         errors++;
         $display("mismatch at %0t: run timed out", $time);
         wrap_up();
      end
   end

   initial
   begin
      CLK_SYS = 1'b0;
      RSTN = 1'b0;
      INSTR_VALID = 1'b0;
      INSTR = '0;
      FLAGS = '0;
      PC = '0;
      IO_RDATA = '0;
      repeat (3) @(posedge CLK_SYS);
      @(negedge CLK_SYS);
      RSTN = 1'b1;
      // every op against every flag pattern, offsets at both extremes, pc wrapping
      for (int o = 0; o < 8; o++)
         for (int f = 0; f < 8; f++)
            issue(fbx_op_t'(o[2:0]), o[0] ? 7'h40 : 7'h3F, fbx_flags_t'(f[2:0]),
               f[0] ? 16'hFFFF : 16'h0000, f[2:0], 8'h5A ^ {8{f[1]}});
      $display("test corner sweep done");
      repeat (300)
      begin
         r = $random(seed);
         r2 = $random(seed);
         issue(fbx_op_t'(r[2:0]), r[9:3], fbx_flags_t'(r[12:10]), r[28:13], r[31:29], r2[7:0]);
      end
      $display("test random mix done");
      INSTR_VALID = 1'b0;
      @(posedge CLK_SYS);
      @(negedge CLK_SYS);
      chk({DONE, BUSY, IO_WE}, 3'h0);
      $display("test idle after drop done");
      // reset lands while a taken branch is in its second cycle; it must not complete
      INSTR = '{FBX_OP_BR_IEN, 7'h05, 6'h00, 3'h0};
      FLAGS = '{1'b0, 1'b0, 1'b1};
      PC = 16'h1234;
      INSTR_VALID = 1'b1;
      @(posedge CLK_SYS);
      @(negedge CLK_SYS);
      chk(BUSY, 1'b1);
      RSTN = 1'b0;
      INSTR_VALID = 1'b0;
      #1;
      chk({BUSY, DONE, PC_LOAD, IO_RD, IO_WE}, 5'h00);
      chk(PC_NEXT, 16'h0000);
      @(negedge CLK_SYS);
      RSTN = 1'b1;
      @(posedge CLK_SYS);
      @(negedge CLK_SYS);
      chk({DONE, PC_LOAD, BUSY}, 3'h0);
      $display("test reset mid branch done");
      wrap_up();
   end
endmodule : flag_branch_and_bit_set_exec_test
